// ==== hdl/ddc_host.sv ====
`timescale 1ns/10ps
`default_nettype none
`include "ddc_map.svh"
// Notes on behaviour
// [R1] Eight-bit bus: high byte written first
// [R2] First write loads all; second overwrites low
// [R3] Auto mode: transfer during second write
// [R4] Second byte also moves whole word
// [R5] Processor mode: transfer on third strobe
// [R6] External mode: outside logic makes transfer
// [R7] One common transfer strobe for many
// [R8] Sixteen-bit bus uses lanes six..fifteen
// [R9] Sixteen-bit bus: byte select held high
// [R10] Ten-bit writes: flow, single, double buffered
// [R11] Stand-alone: single or double buffered
// [R12] Byte select from address bit zero
// [R13] Incrementing double store starts odd address
// [R14] Chip select aligned with both strobes; here flow-through writes and some transfer strobes fall outside CS_N
// [R15] Low transfer strobe: register follows latch
// [R16] Latch transparent while select and write low
module ddc_host
   import ddc_pkg::*;
#(
   parameter int STROBE_CYC = `DDC_STROBE_CYC,
   parameter int GAP_CYC = `DDC_GAP_CYC
) (
   // Clock and reset
   input wire logic REF_CLK,
   input wire logic NRST,
   // User command port
   input wire logic CMD_VALID,
   output logic CMD_READY,
   input wire ddc_pkg::ddc_mode_e CMD_MODE,
   input wire ddc_pkg::ddc_word_t CMD_WORD,
   input wire logic EXT_TRANSFER_STROBE_N_N,
   output logic CMD_DONE,
   // Device pins
   output logic CS_N,
   output logic WR_N,
   output logic TRANSFER_STROBE_N,
   output logic BYTE_ORDER_SELECT,
   output ddc_pkg::ddc_bus_t DBUS,
   output logic ADDR0
);
   import ddc_pkg::*;

   // ----------------------------------------
   // Sequencer
   // ----------------------------------------
   typedef enum logic [2:0] {
      ST_IDLE, ST_GAP, ST_HI, ST_LO, ST_XF, ST_FIN
   } ddc_state_e;

   ddc_state_e state_reg, state_next;
   ddc_mode_e mode_reg;
   logic [7:0] cnt_reg;
   logic phase_reg; // 0 gap before strobe, 1 strobe low
   ddc_word_t word;
   logic cap;
   logic strobing;
   logic seq_end;

   assign cap = CMD_VALID && CMD_READY;
   assign CMD_READY = (state_reg == ST_IDLE);

   // Pending word held so command inputs may change
   ddc_word_reg #(.W(`DDC_WORD_W)) u_word (
      .clk(REF_CLK),
      .rst_n(NRST),
      .wr_en(cap),
      .wr_data(CMD_WORD),
      .rd_data(word)
   );

   // Mode captured with the word
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         mode_reg <= DDC_AUTO;
      end else if (cap) begin
         mode_reg <= CMD_MODE;
      end
   end

   // Strobe phase counter: gap then low pulse per write
   assign seq_end = phase_reg && (cnt_reg == 8'(STROBE_CYC - 1));
   always_ff @(posedge REF_CLK) begin
      if (!NRST || state_reg == ST_IDLE || state_reg == ST_FIN) begin
         cnt_reg <= 8'h00;
         phase_reg <= 1'b0;
      end else if (!phase_reg && cnt_reg == 8'(GAP_CYC - 1)) begin
         cnt_reg <= 8'h00;
         phase_reg <= 1'b1;
      end else if (seq_end) begin
         cnt_reg <= 8'h00;
         phase_reg <= 1'b0;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end
   assign strobing = phase_reg && (state_reg inside {ST_HI, ST_LO, ST_XF});

   // Next state by mode
   always_comb begin
      state_next = state_reg;
      case (state_reg)
         ST_IDLE: if (cap) state_next = ST_GAP;
         ST_GAP: state_next = ST_HI;
         ST_HI: begin
            if (seq_end) begin
               case (mode_reg)
                  DDC_AUTO, DDC_UPXF, DDC_EXTX: state_next = ST_LO; // R1
                  DDC_W16D: state_next = ST_XF; // R10
                  default: state_next = ST_FIN;
               endcase
            end
         end
         ST_LO: begin
            if (seq_end) begin
               state_next = (mode_reg == DDC_UPXF) ? ST_XF : ST_FIN; // R5
            end
         end
         ST_XF: if (seq_end) state_next = ST_FIN;
         ST_FIN: state_next = ST_IDLE;
         default: state_next = ST_IDLE;
      endcase
   end

   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         state_reg <= ST_IDLE;
      end else begin
         state_reg <= state_next;
      end
   end

   // Completion pulse
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         CMD_DONE <= 1'b0;
      end else begin
         CMD_DONE <= (state_reg == ST_FIN);
      end
   end

   // ----------------------------------------
   // Pin drive, registered
   // ----------------------------------------
   // Pins follow the registered state, in step with the lagged write strobe,
   // so a new byte never reaches the bus while the previous strobe is still low
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         DBUS <= 16'h0000;
         BYTE_ORDER_SELECT <= 1'b1;
         ADDR0 <= 1'b1;
      end else begin
         case (state_reg)
            ST_HI: begin
               // First write carries the high group in the top lanes
               DBUS <= {word, 6'h00}; // R2 R8
               BYTE_ORDER_SELECT <= 1'b1; // R9 R12
               ADDR0 <= 1'b1; // R13
            end
            ST_LO: begin
               // Low group on the low byte lanes, top bits of low byte
               DBUS <= {8'h00, word[`DDC_LOW_W-1:0], 6'h00}; // R2
               BYTE_ORDER_SELECT <= 1'b0; // R12
               ADDR0 <= 1'b0;
            end
            default: begin
               DBUS <= DBUS;
               BYTE_ORDER_SELECT <= BYTE_ORDER_SELECT;
               ADDR0 <= ADDR0;
            end
         endcase
      end
   end

   // Chip select covers every write strobe except the flow-through hold; the transfer strobe can fall outside it; same one-cycle lag as the strobes
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         CS_N <= 1'b1;
      end else begin
         CS_N <= !(state_reg inside {ST_HI, ST_LO, ST_XF}); // R14
      end
   end

   // Write strobe; flow-through keeps it low until the sequence returns to idle
   logic wr_low;
   assign wr_low = strobing || (mode_reg == DDC_FLOW && state_reg != ST_IDLE);
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         WR_N <= 1'b1;
      end else begin
         WR_N <= !((strobing && state_reg != ST_XF) ||
                   (strobing && state_reg == ST_XF && mode_reg == DDC_UPXF) ||
                   (wr_low && mode_reg == DDC_FLOW)); // R16 R11
      end
   end

   // Transfer strobe by mode
   logic xf_low;
   always_comb begin
      case (mode_reg)
         DDC_AUTO: xf_low = strobing && state_reg == ST_LO; // R3 R4
         DDC_UPXF: xf_low = strobing && state_reg == ST_XF; // R5 R7
         DDC_EXTX: xf_low = !EXT_TRANSFER_STROBE_N_N; // R6
         DDC_W16S, DDC_FLOW: xf_low = state_reg != ST_IDLE; // R10
         DDC_W16D: xf_low = strobing && state_reg == ST_XF; // R15
         default: xf_low = 1'b0;
      endcase
   end
   always_ff @(posedge REF_CLK) begin
      if (!NRST) begin
         TRANSFER_STROBE_N <= 1'b1;
      end else begin
         TRANSFER_STROBE_N <= !xf_low; // R15
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   property p_sel_first_high;
      @(posedge REF_CLK) disable iff (!NRST)
         $fell(CS_N) |-> BYTE_ORDER_SELECT;
   endproperty
   a_sel_first_high: assert property (p_sel_first_high) // R1
      else $error("first write not high byte");

   property p_cs_cover_wr;
      @(posedge REF_CLK) disable iff (!NRST)
         (!WR_N && mode_reg != DDC_FLOW) |-> !CS_N;
   endproperty
   a_cs_cover_wr: assert property (p_cs_cover_wr) // R14
      else $error("write strobe outside chip select");

   property p_auto_xf;
      @(posedge REF_CLK) disable iff (!NRST)
         (mode_reg == DDC_AUTO && !TRANSFER_STROBE_N) |-> !WR_N && !BYTE_ORDER_SELECT;
   endproperty
   a_auto_xf: assert property (p_auto_xf) // R3
      else $error("auto transfer outside second write");

   property p_done;
      @(posedge REF_CLK) disable iff (!NRST)
         cap |-> ##[3:60] CMD_DONE;
   endproperty
   a_done: assert property (p_done) // R5
      else $error("sequence did not finish");

   property p_upxf_third;
      @(posedge REF_CLK) disable iff (!NRST)
         (mode_reg == DDC_UPXF && !TRANSFER_STROBE_N) |-> !WR_N && !CS_N;
   endproperty
   a_upxf_third: assert property (p_upxf_third) // R5
      else $error("processor transfer without write strobe");

   property p_w16_sel;
      @(posedge REF_CLK) disable iff (!NRST)
         (mode_reg inside {DDC_W16S, DDC_W16D} && !WR_N) |-> BYTE_ORDER_SELECT;
   endproperty
   a_w16_sel: assert property (p_w16_sel) // R10
      else $error("ten-bit write without byte select high");

   c_auto: cover property (@(posedge REF_CLK) cap && CMD_MODE == DDC_AUTO);
   c_upxf: cover property (@(posedge REF_CLK) cap && CMD_MODE == DDC_UPXF);
   c_w16d: cover property (@(posedge REF_CLK) cap && CMD_MODE == DDC_W16D);
endmodule // ddc_host
`default_nettype wire

// ==== hdl/ddc_map.svh ====
`ifndef DDC_MAP_SVH
`define DDC_MAP_SVH
// ----------------------------------------
// Widths and bus lane positions
// ----------------------------------------
`define DDC_WORD_W 10
`define DDC_BUS16_LSB 6
`define DDC_BUS16_MSB 15
`define DDC_LOW_W 2
// ----------------------------------------
// Strobe timing
// ----------------------------------------
// Strobe low width in ns, and gap between strobes in ns
`define DDC_STROBE_NS 120
`define DDC_GAP_NS 80
`define DDC_CLK_NS 40
// Least times round up
`define DDC_STROBE_CYC ((`DDC_STROBE_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
`define DDC_GAP_CYC ((`DDC_GAP_NS + `DDC_CLK_NS - 1) / `DDC_CLK_NS)
// Mode codes
`define DDC_MODE_AUTO 3'h0
`define DDC_MODE_UPXF 3'h1
`define DDC_MODE_EXTX 3'h2
`define DDC_MODE_W16S 3'h3
`define DDC_MODE_W16D 3'h4
`define DDC_MODE_FLOW 3'h5
`endif

// ==== hdl/ddc_pkg.sv ====
package ddc_pkg;
   typedef enum logic [2:0] {
      DDC_AUTO, DDC_UPXF, DDC_EXTX, DDC_W16S, DDC_W16D, DDC_FLOW
   } ddc_mode_e;
   typedef logic [9:0] ddc_word_t;
   typedef logic [15:0] ddc_bus_t;
endpackage

// ==== hdl/ddc_word_reg.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Holding register for one pending word
// ----------------------------------------
module ddc_word_reg #(
   parameter int W = 10
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Write side
   input wire logic wr_en,
   input wire logic [W-1:0] wr_data,
   // Read side
   output logic [W-1:0] rd_data
);
   logic [W-1:0] mem_reg;
   // Captured word, read data from flip-flop
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         mem_reg <= '0;
      end else if (wr_en) begin
         mem_reg <= wr_data;
      end
   end
   assign rd_data = mem_reg;
endmodule // ddc_word_reg
`default_nettype wire

// ==== tb/ddc_dev_model.sv ====
`timescale 1ns/10ps
`default_nettype none
// ----------------------------------------
// Converter input side, two latch stages
// ----------------------------------------
module ddc_dev_model (
   // Device pins
   input wire logic cs_n,
   input wire logic wr_n,
   input wire logic transfer_strobe_n,
   input wire logic byte_order_select,
   input wire ddc_pkg::ddc_bus_t dbus,
   // Observed stages
   output var ddc_pkg::ddc_word_t latch_word,
   output var ddc_pkg::ddc_word_t dac_word
);
   import ddc_pkg::*;
   // Input latch open while select and write both low
   always @* begin
      if (!cs_n && !wr_n) begin
         if (byte_order_select) begin
            latch_word = dbus[15:6];
         end else begin
            latch_word[1:0] = dbus[7:6];
         end
      end
   end
   // Converter stage follows latch, so a late transfer edge shows up
   always @* begin
      if (!transfer_strobe_n) begin
         dac_word = latch_word;
      end
   end
endmodule // ddc_dev_model
`default_nettype wire

// ==== tb/testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, g) begin num_checks++; if ((g) !== (e)) begin miscompares++; \
   $display("[FAIL] %s expected %h seen %h", nm, e, g); end end
// ----------------------------------------
// Bench: corner words in every mode, then random words in random modes
// ----------------------------------------
module testbench;
   import ddc_pkg::*;
   logic REF_CLK = 1'b0;
   logic NRST = 1'b0;
   logic CMD_VALID = 1'b0;
   logic EXT_TRANSFER_STROBE_N_N = 1'b1;
   ddc_mode_e CMD_MODE = DDC_AUTO;
   ddc_word_t CMD_WORD = '0;
   logic CMD_READY, CMD_DONE, CS_N, WR_N, TRANSFER_STROBE_N, BYTE_ORDER_SELECT, ADDR0;
   ddc_bus_t DBUS;
   ddc_word_t latch_word, dac_word, prev;
   int miscompares = 0;
   int num_checks = 0;
   // Clock, 40 ns period
   always #20 REF_CLK = ~REF_CLK;
   ddc_host u_dut (.REF_CLK(REF_CLK), .NRST(NRST), .CMD_VALID(CMD_VALID),
      .CMD_READY(CMD_READY), .CMD_MODE(CMD_MODE), .CMD_WORD(CMD_WORD),
      .EXT_TRANSFER_STROBE_N_N(EXT_TRANSFER_STROBE_N_N), .CMD_DONE(CMD_DONE), .CS_N(CS_N), .WR_N(WR_N),
      .TRANSFER_STROBE_N(TRANSFER_STROBE_N), .BYTE_ORDER_SELECT(BYTE_ORDER_SELECT),
      .DBUS(DBUS), .ADDR0(ADDR0));
   ddc_dev_model u_dev (.cs_n(CS_N), .wr_n(WR_N), .transfer_strobe_n(TRANSFER_STROBE_N),
      .byte_order_select(BYTE_ORDER_SELECT), .dbus(DBUS), .latch_word(latch_word),
      .dac_word(dac_word));
   // External mode keeps the old output until the outside strobe
   function automatic ddc_word_t expect_dac(ddc_mode_e m, ddc_word_t w, ddc_word_t old);
      return (m == DDC_EXTX) ? old : w;
   endfunction
   // Eight-bit modes end on the low byte write; ten-bit ones stay high
   function automatic logic [1:0] expect_sel(ddc_mode_e m);
      return (m inside {DDC_AUTO, DDC_UPXF, DDC_EXTX}) ? 2'b00 : 2'b11;
   endfunction
   task automatic close_out;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // Bounded wait at falling edges for a level
   task automatic wait_for(input bit want_done);
      int n;
      n = 0;
      while ((want_done ? CMD_DONE : CMD_READY) !== 1'b1 && n < 200) begin
         @(negedge REF_CLK);
         n++;
      end
      if (n >= 200) begin
         miscompares++;
         close_out();
      end
   endtask
   task automatic send(input ddc_mode_e m, input ddc_word_t w);
      @(negedge REF_CLK);
      CMD_MODE = m;
      CMD_WORD = w;
      wait_for(1'b0);
      CMD_VALID = 1'b1;
      @(negedge REF_CLK);
      CMD_VALID = 1'b0;
      wait_for(1'b1);
      @(negedge REF_CLK);
      `CHK("latch", w, latch_word)
      `CHK("dac", expect_dac(m, w, prev), dac_word)
      `CHK("idle", 4'b1111, {CS_N, WR_N, TRANSFER_STROBE_N, CMD_READY})
      `CHK("sel", expect_sel(m), {BYTE_ORDER_SELECT, ADDR0})
      if (m == DDC_EXTX) begin
         EXT_TRANSFER_STROBE_N_N = 1'b0;
         repeat (3) @(negedge REF_CLK);
         EXT_TRANSFER_STROBE_N_N = 1'b1;
         repeat (2) @(negedge REF_CLK);
         `CHK("ext", w, dac_word)
      end
      prev = w;
   endtask
   initial begin
      ddc_word_t w;
      void'($urandom(26574));
      prev = '0;
      repeat (16) @(negedge REF_CLK);
      NRST = 1'b1;
      // Corner words in every mode, back to back
      for (int k = 0; k < 6; k++) begin
         send(ddc_mode_e'(k), 10'h3ff);
         send(ddc_mode_e'(k), 10'h000);
         send(ddc_mode_e'(k), 10'h2a9);
      end
      for (int i = 0; i < 40; i++) begin
         w = ddc_word_t'($urandom);
         send(ddc_mode_e'($urandom_range(0, 5)), w);
      end
      close_out();
   end
endmodule // testbench
`default_nettype wire
